// file: verilog/capsense_ctrl.sv
// Control and status logic of the capacitive sensing oscillator, with the
// Timer0 and Timer1 clock steering and an AXI4-Lite register slave.
// Assumes the oscillator output, its phase and the Timer0 clock pin arrive
// asynchronously; sleep and the timer source fields come from SYS_CLK logic.
`timescale 1ns/10ps

module capsense_ctrl
  import capsense_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire axil_req_t AXI_REQ,
  output axil_rsp_t AXI_RSP,
  input wire logic OSC_IN,
  input wire logic PHASE_IN,
  input wire logic T0_PIN_IN,
  input wire logic SLEEP,
  input wire logic T0_CLOCK_SELECT,
  input wire logic [1:0] T1_SOURCE_FIELD,
  output osc_ctrl_t OSC_CTRL,
  output logic TMR0_CLK,
  output logic TMR1_OSC_SEL,
  output logic TMR1_CLK
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic rng;
    logic [1:0] cur;
    logic t0x;
    logic [3:0] chan;
    logic osc_s1;
    logic osc_s2;
    logic ph_s1;
    logic ph_s2;
    logic phase;
    logic pin_s1;
    logic pin_s2;
    logic [1:0] div;
    logic aw_have;
    logic [ADDR_W-1:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wstrb0;
    wr_state_t wr_st;
    logic [1:0] bresp;
    rd_state_t rd_st;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic rst_s1_q;
  logic rst_n;
  logic osc_runs;

  // Reset release through two flip-flops; assertion stays asynchronous.
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Oscillator active when enabled, unless low range with the off code.
  assign osc_runs = s_q.en && (s_q.rng || s_q.cur != CUR_OFF);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Synchronisers, core divider, register writes and reads.
  always_comb begin
    s_d = s_q;
    s_d.osc_s1 = OSC_IN;
    s_d.osc_s2 = s_q.osc_s1;
    s_d.ph_s1 = PHASE_IN;
    s_d.ph_s2 = s_q.ph_s1;
    s_d.pin_s1 = T0_PIN_IN;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.phase = osc_runs && s_q.ph_s2;
    s_d.div = s_q.div + 2'h1;
    if (AXI_REQ.awvalid && AXI_RSP.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = AXI_REQ.awaddr;
    end
    if (AXI_REQ.wvalid && AXI_RSP.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = AXI_REQ.wdata[7:0];
      s_d.wstrb0 = AXI_REQ.wstrb[0];
    end
    case (s_q.wr_st)
      WR_IDLE: begin
        if (s_q.aw_have && s_q.w_have) begin
          s_d.aw_have = 1'b0;
          s_d.w_have = 1'b0;
          s_d.wr_st = WR_RESP;
          s_d.bresp = RESP_OKAY;
          if (s_q.awaddr == CTRL_OFS) begin
            if (s_q.wstrb0) begin
              // Bits 5, 4 and 1 are not stored.
              s_d.en = s_q.wdata[EN_BIT];
              s_d.rng = s_q.wdata[RANGE_BIT];
              s_d.cur = s_q.wdata[CUR_LSB+:2];
              s_d.t0x = s_q.wdata[T0X_BIT];
            end
          end else if (s_q.awaddr == CHAN_OFS) begin
            if (s_q.wstrb0) begin
              s_d.chan = s_q.wdata[CHAN_LSB+:4];
            end
          end else begin
            s_d.bresp = RESP_SLVERR;
          end
        end
      end
      WR_RESP: begin
        if (AXI_REQ.bready) begin
          s_d.wr_st = WR_IDLE;
        end
      end
      default: begin
        s_d.wr_st = WR_IDLE;
      end
    endcase
    case (s_q.rd_st)
      RD_IDLE: begin
        if (AXI_REQ.arvalid) begin
          s_d.rd_st = RD_DATA;
          s_d.rresp = RESP_OKAY;
          s_d.rdata = 8'h00;
          if (AXI_REQ.araddr == CTRL_OFS) begin
            s_d.rdata[EN_BIT] = s_q.en;
            s_d.rdata[RANGE_BIT] = s_q.rng;
            s_d.rdata[CUR_LSB+:2] = s_q.cur;
            s_d.rdata[PHASE_BIT] = s_q.phase;
            s_d.rdata[T0X_BIT] = s_q.t0x;
          end else if (AXI_REQ.araddr == CHAN_OFS) begin
            s_d.rdata[CHAN_LSB+:4] = s_q.chan;
          end else begin
            s_d.rresp = RESP_SLVERR;
          end
        end
      end
      RD_DATA: begin
        if (AXI_REQ.rready) begin
          s_d.rd_st = RD_IDLE;
        end
      end
      default: begin
        s_d.rd_st = RD_IDLE;
      end
    endcase
  end

  // State register; reset clears every field except the write and read states, which load WR_IDLE and RD_IDLE.
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.wr_st <= WR_IDLE;
      s_q.rd_st <= RD_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Bus answers.
  always_comb begin
    AXI_RSP.awready = !s_q.aw_have && s_q.wr_st == WR_IDLE;
    AXI_RSP.wready = !s_q.w_have && s_q.wr_st == WR_IDLE;
    AXI_RSP.bvalid = s_q.wr_st == WR_RESP;
    AXI_RSP.bresp = s_q.bresp;
    AXI_RSP.arready = s_q.rd_st == RD_IDLE;
    AXI_RSP.rvalid = s_q.rd_st == RD_DATA;
    AXI_RSP.rdata = {24'h000000, s_q.rdata};
    AXI_RSP.rresp = s_q.rresp;
  end

  // Oscillator steering; sleep does not reach it.
  always_comb begin
    OSC_CTRL.module_on = s_q.en;
    OSC_CTRL.high_range = s_q.rng;
    OSC_CTRL.current_code = s_q.en ? s_q.cur : CUR_OFF;
    OSC_CTRL.osc_run = osc_runs;
    OSC_CTRL.noise_detect = osc_runs && s_q.rng && s_q.cur == CUR_OFF;
    OSC_CTRL.channel_on = '0;
    if (s_q.en) begin
      OSC_CTRL.channel_on[s_q.chan] = 1'b1;
    end
  end

  // Timer clock steering; Timer0 is held low in sleep.
  always_comb begin
    if (SLEEP) begin
      TMR0_CLK = 1'b0;
    end else if (!T0_CLOCK_SELECT) begin
      TMR0_CLK = s_q.div[1];
    end else begin
      TMR0_CLK = s_q.t0x ? s_q.osc_s2 : s_q.pin_s2;
    end
    TMR1_OSC_SEL = T1_SOURCE_FIELD == T1_OSC_CODE;
    TMR1_CLK = TMR1_OSC_SEL && s_q.osc_s2;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n);

  enable_bit_a: assert property (
    AXI_RSP.bvalid && $rose(AXI_RSP.bvalid) && s_q.bresp == RESP_OKAY
    |-> OSC_CTRL.module_on == s_q.en)
    else $error("Module enable does not follow its bit.");

  range_out_a: assert property (
    OSC_CTRL.high_range == s_q.rng)
    else $error("Range output differs from range bit.");

  low_off_a: assert property (
    s_q.en && !s_q.rng && s_q.cur == CUR_OFF |-> !OSC_CTRL.osc_run)
    else $error("Oscillator runs with low range off code.");

  noise_mode_a: assert property (
    s_q.en && s_q.rng && s_q.cur == CUR_OFF
    |-> OSC_CTRL.osc_run && OSC_CTRL.noise_detect)
    else $error("Noise detection not entered.");

  phase_read_a: assert property (
    AXI_REQ.arvalid && AXI_RSP.arready && AXI_REQ.araddr == CTRL_OFS
    |=> AXI_RSP.rdata[PHASE_BIT] == $past(s_q.phase))
    else $error("Phase status read wrong.");

  t0_ext_a: assert property (
    !SLEEP && T0_CLOCK_SELECT && s_q.t0x |-> TMR0_CLK == s_q.osc_s2)
    else $error("Timer0 not on the oscillator.");

  // Only judged while internal mode holds over the whole period.
  t0_quarter_a: assert property (
    (!SLEEP && !T0_CLOCK_SELECT) [*2] ##0 $rose(TMR0_CLK)
    ##1 (!SLEEP && !T0_CLOCK_SELECT) [*4]
    |-> $rose(TMR0_CLK) && !$past(TMR0_CLK, 2) && $past(TMR0_CLK, 3))
    else $error("Timer0 internal clock not a quarter rate.");

  chan_onehot_a: assert property (
    s_q.en |-> $onehot(OSC_CTRL.channel_on)
    && OSC_CTRL.channel_on[s_q.chan])
    else $error("Channel decode wrong.");

  chan_none_a: assert property (
    !s_q.en |-> OSC_CTRL.channel_on == '0)
    else $error("Channel connected while disabled.");

  sleep_run_a: assert property (
    SLEEP && s_q.en && s_q.rng |-> OSC_CTRL.osc_run)
    else $error("Oscillator stopped in sleep.");

  sleep_halt_a: assert property (
    SLEEP |-> !TMR0_CLK)
    else $error("Timer0 clocked in sleep.");

  unimpl_zero_a: assert property (
    AXI_RSP.rvalid |-> AXI_RSP.rdata[31:8] == 24'h000000
    && (AXI_RSP.rdata[5:4] == 2'h0 || AXI_RSP.rresp != RESP_OKAY))
    else $error("Unimplemented bits read nonzero.");

  t1_source_a: assert property (
    TMR1_OSC_SEL |-> TMR1_CLK == s_q.osc_s2)
    else $error("Timer1 not on the oscillator.");

  write_cv: cover property (
    AXI_RSP.bvalid && AXI_REQ.bready && s_q.bresp == RESP_OKAY);
  read_cv: cover property (AXI_RSP.rvalid && AXI_REQ.rready);
  noise_cv: cover property (OSC_CTRL.noise_detect);
  sleep_cv: cover property (SLEEP && OSC_CTRL.osc_run);

endmodule

// file: verilog/capsense_pkg.sv
// Constants, field layouts and carrier types of the capacitive sensing
// control block.
// Assumes an AXI4-Lite master with 32-bit data and a 4-bit byte address.
package capsense_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] CHAN_OFS = 4'h4;
  localparam int EN_BIT = 7;
  localparam int RANGE_BIT = 6;
  localparam int CUR_LSB = 2;
  localparam int PHASE_BIT = 1;
  localparam int T0X_BIT = 0;
  localparam int CHAN_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CHAN_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] CUR_OFF = 2'h0;
  localparam logic [1:0] T1_OSC_CODE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CORE_DIV = 4;
  localparam int NUM_CHAN = 16;

  // Write and read channel states.
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

  // AXI4-Lite signals driven by the master.
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_t;

  // AXI4-Lite signals driven by this slave.
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  // Steering of the analog sensing oscillator.
  typedef struct packed {
    logic module_on;
    logic high_range;
    logic [1:0] current_code;
    logic osc_run;
    logic noise_detect;
    logic [NUM_CHAN-1:0] channel_on;
  } osc_ctrl_t;

endpackage

// file: tb/osc_model.sv
// Behavioural model of the analog sensing oscillator beside the block.
// Assumes one clock; it oscillates only while the block lets it run.
`timescale 1ns/10ps

module osc_model
  import capsense_pkg::*;
(
  input wire logic clk,
  input wire osc_ctrl_t ctrl,
  output logic osc,
  output logic phase
);
  logic [2:0] cnt_q = 3'h0;
  logic osc_q = 1'b0;

  // Toggles every eight clocks; noise mode has no current, so it stalls.
  always_ff @(posedge clk) begin
    cnt_q <= cnt_q + 3'h1;
    if (ctrl.osc_run && !ctrl.noise_detect && cnt_q == 3'h7) begin
      osc_q <= ~osc_q;
    end
  end

  // The pin sources current while the output is high.
  assign osc = osc_q;
  assign phase = osc_q;
endmodule

// file: tb/tb.sv
// Self-checking bench of the sensing control block and its registers.
// Assumes the AXI4-Lite slave and the oscillator model beside it.
`timescale 1ns/10ps
`define check_eq(nm, ex, gt) begin \
  cmp_count++; \
  if ((gt) !== (ex)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); \
  end \
end

module tb
  import capsense_pkg::*;
;
  typedef struct packed {
    logic [7:0] wc, wn, rc, rn;
    logic run, noise;
  } row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic osc, phase, tmr0, t1sel, tmr1;
  logic t0_pin = 1'b0;
  logic sleep = 1'b0;
  logic t0_sel = 1'b0;
  logic [1:0] t1_field = 2'h0;
  osc_ctrl_t ctl;
  logic [2:0] mon;
  int n_errors = 0;
  int cmp_count = 0;
  const row_t rows[9] = '{
    '{8'h00, 8'h05, 8'h00, 8'h05, 1'b0, 1'b0},
    '{8'hff, 8'hff, 8'hcd, 8'h0f, 1'b1, 1'b0},
    '{8'h80, 8'h00, 8'h80, 8'h00, 1'b0, 1'b0},
    '{8'h84, 8'h01, 8'h84, 8'h01, 1'b1, 1'b0},
    '{8'h88, 8'h08, 8'h88, 8'h08, 1'b1, 1'b0},
    '{8'h8c, 8'h0e, 8'h8c, 8'h0e, 1'b1, 1'b0},
    '{8'hc0, 8'h0f, 8'hc0, 8'h0f, 1'b1, 1'b1},
    '{8'hc4, 8'h03, 8'hc4, 8'h03, 1'b1, 1'b0},
    '{8'h4c, 8'h0a, 8'h4c, 8'h0a, 1'b0, 1'b0}};

  assign mon = {tmr1, osc, tmr0};

  capsense_ctrl DUT (.SYS_CLK(clk), .RESETN(rst_n), .AXI_REQ(req),
    .AXI_RSP(rsp), .OSC_IN(osc), .PHASE_IN(phase), .T0_PIN_IN(t0_pin),
    .SLEEP(sleep), .T0_CLOCK_SELECT(t0_sel), .T1_SOURCE_FIELD(t1_field),
    .OSC_CTRL(ctl), .TMR0_CLK(tmr0), .TMR1_OSC_SEL(t1sel),
    .TMR1_CLK(tmr1));

  osc_model partner (.clk(clk), .ctrl(ctl), .osc(osc), .phase(phase));

  // Free-running 250 MHz clock.
  initial begin
    forever #2 clk = ~clk;
  end

  // Write one register; both items offered together, held until taken.
  task automatic axw(input logic [3:0] a, input logic [7:0] d,
                     output logic [1:0] r);
    logic aok, wok, bok;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(negedge clk);
      aok = req.awvalid && rsp.awready;
      wok = req.wvalid && rsp.wready;
      bok = rsp.bvalid;
      r = rsp.bresp;
      @(posedge clk);
      if (aok) req.awvalid <= 1'b0;
      if (wok) req.wvalid <= 1'b0;
    end while (!bok);
    req.bready <= 1'b0;
  endtask

  // Read one register and its response code.
  task automatic axr(input logic [3:0] a, output logic [7:0] d,
                     output logic [1:0] r);
    logic aok, rok;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(negedge clk);
      aok = req.arvalid && rsp.arready;
      rok = rsp.rvalid;
      d = rsp.rdata[7:0];
      r = rsp.rresp;
      @(posedge clk);
      if (aok) req.arvalid <= 1'b0;
    end while (!rok);
    req.rready <= 1'b0;
  endtask

  // Counts rising edges of one watched clock over 64 cycles.
  // The window is the bench clock, never the timer being counted, and it
  // is the same for every measurement; it returns just after a rising edge.
  task automatic count(input int i, output int n);
    logic p;
    n = 0;
    repeat (4) @(negedge clk);
    p = mon[i];
    repeat (64) begin
      @(negedge clk);
      if (mon[i] && !p) n++;
      p = mon[i];
    end
    @(posedge clk);
  endtask

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run time.
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  // Table of register settings, then timer steering, sleep and reset.
  initial begin
    logic [7:0] d, m, w;
    logic [1:0] r;
    int n;
    int nn;
    osc_ctrl_t e;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      w = rows[i].wc;
      axw(CTRL_OFS, w, r);
      axw(CHAN_OFS, rows[i].wn, r);
      axr(CTRL_OFS, d, r);
      m = rows[i].run ? 8'hfd : 8'hff;
      `check_eq("ctrl", rows[i].rc & m, d & m)
      axr(CHAN_OFS, d, r);
      `check_eq("chan", rows[i].rn, d)
      e = {w[7], w[6], w[7] ? w[3:2] : 2'h0, rows[i].run, rows[i].noise,
           w[7] ? 16'h1 << rows[i].wn[3:0] : 16'h0};
      `check_eq("osc", e, ctl)
    end
    axw(4'h8, 8'hff, r);
    `check_eq("bresp", RESP_SLVERR, r)
    axr(4'h8, d, r);
    `check_eq("rresp", RESP_SLVERR, r)
    `check_eq("rdata", 8'h00, d)
    axw(CTRL_OFS, 8'h8d, r);
    `check_eq("okay", RESP_OKAY, r)
    count(0, n);
    `check_eq("t0core", 16, n)
    t0_sel <= 1'b1;
    count(0, n);
    `check_eq("t0osc", 4, n)
    sleep <= 1'b1;
    count(0, n);
    `check_eq("runsleep", 1'b1, ctl.osc_run)
    sleep <= 1'b0;
    `check_eq("t0sleep", 0, n)
    `check_eq("t1off", 1'b0, t1sel)
    t1_field <= T1_OSC_CODE;
    count(2, n);
    `check_eq("t1osc", 4, n)
    `check_eq("t1sel", 1'b1, t1sel)
    nn = n;
    axw(CTRL_OFS, 8'hc0, r);
    count(2, n);
    `check_eq("thresh", 1'b1, n < (nn + n) / 2)
    axr(CTRL_OFS, d, r);
    `check_eq("phase", osc, d[PHASE_BIT])
    axw(CTRL_OFS, 8'h8c, r);
    t0_pin <= 1'b1;
    repeat (4) @(posedge clk);
    `check_eq("t0pin", 1'b1, tmr0)
    t0_pin <= 1'b0;
    repeat (4) @(posedge clk);
    `check_eq("t0pinlo", 1'b0, tmr0)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    axr(CTRL_OFS, d, r);
    `check_eq("rstctrl", 8'h00, d)
    axr(CHAN_OFS, d, r);
    `check_eq("rstchan", 8'h00, d)
    `check_eq("rstosc", 22'h0, ctl)
    wrap_up();
  end
endmodule
